// file: pkg/spk_dac_cfg.svh
// Offsets, field positions, reset values and timing counts of the speaker DAC control
`ifndef SPK_DAC_CFG_SVH
`define SPK_DAC_CFG_SVH

// Printed offsets are not all multiples of four, so each is kept as an index
// and the byte address is four times the index
`define IDX_SETTLE         32'h0b000164
`define IDX_SAMPLE         32'h0b000166
`define IDX_CONTROL        32'h0b000168
`define IDX_SEQ            32'h0b00016a
`define IDX_IRQ_STAT       32'h0b00016c
`define IDX_IRQ_MASK       32'h0b00016d
`define IDX_DMA_SAMPLE     32'h0b000160

`define ADDR_W             32
`define BYTE_ADDR(idx)     (((idx) << 2) & 32'hffffffff)

`define SETTLE_RESET       16'h007d
`define SAMPLE_MIDSCALE    10'h200
`define SAMPLE_W           10

`define CTL_REF_EN_BIT     15
`define CTL_RUNNING_BIT    3
`define CTL_PAGE_STOP_BIT  1
`define SEQ_SPK_EN_BIT     0

`define IRQ_W              2
`define IRQ_SETTLED_BIT    0
`define IRQ_UNDERRUN_BIT   1

`define SETTLE_US          5
`define CLK_MHZ            200
`define SETTLE_CYCLES      (`SETTLE_US * `CLK_MHZ)

`define RESP_OKAY          2'b00
`define RESP_SLVERR        2'b10

`endif

// file: pkg/spk_dac_pkg.sv
// Types shared by the speaker DAC control block
`default_nettype none
package spk_dac_pkg;

   typedef enum logic [1:0] {
      ST_OFF    = 2'b00,
      ST_SETTLE = 2'b01,
      ST_RUN    = 2'b11
   } spk_state_t;

endpackage

`default_nettype wire

// file: rtl/settle_timer.sv
// Reference settling counter for the speaker converter
`timescale 1ns/1ps
`default_nettype none

module settle_timer (
   input  wire logic        sys_clk,
   input  wire logic        srst,
   input  wire logic        start,
   input  wire logic        clear,
   input  wire logic [15:0] limit,
   output logic             done
);

   logic [15:0] cnt_ff;
   logic        busy_ff;
   logic        done_ff;
   logic [15:0] nxt_cnt;
   logic        hit;

   assign hit     = busy_ff && (cnt_ff >= limit);
   assign nxt_cnt = 16'(cnt_ff + 16'h0001);
   assign done    = done_ff;

   // One cycle per count, so done rises the count plus one clock cycles after start
   always_ff @(posedge sys_clk) begin
      if (srst || clear) begin
         cnt_ff  <= 16'h0000;
         busy_ff <= 1'b0;
         done_ff <= 1'b0;
      end else if (start) begin
         cnt_ff  <= 16'h0000;
         busy_ff <= 1'b1;
         done_ff <= 1'b0;
      end else if (hit) begin
         busy_ff <= 1'b0;
         done_ff <= 1'b1;
      end else if (busy_ff) begin
         cnt_ff  <= nxt_cnt;
      end
   end

endmodule

`default_nettype wire

// file: rtl/speaker_dac_output_control.sv
// Speaker DAC output control with AXI4-Lite register access
//
// Notes on behaviour
// R1 - Sixteen-bit settle count sets reference settling time in clock cycles.
// R2 - Software loads settle count with five microseconds times clock rate.
// R3 - Sample register holds ten bits from DMA sample, drives the converter.
// R4 - Reserved bits of sample and control registers read zero, ignore writes.
// R5 - Software sample writes take effect only while block enable is one.
// R6 - Clearing block enable forces the sample register to midscale 0x200.
// R7 - Control bit 15 connects converter supply and reference to the ladder.
// R8 - Software keeps reference enable off when the converter is unused.
// R9 - Read-only control bit 3 shows one while speaker output runs.
// R10 - Software trusts running flag only while block enable is one.
// R11 - Control bit 1 picks DMA stop at one-page or two-page boundary.
// R12 - When the sample register is empty, take the next DMA sample.
// R13 - After reference enable, wait the settle count before presenting samples.
`timescale 1ns/1ps
`default_nettype none
`include "spk_dac_cfg.svh"

module speaker_dac_output_control
   import spk_dac_pkg::*;
#(
   parameter int SAMPLE_W = `SAMPLE_W
) (
   input  wire logic                sys_clk,
   input  wire logic                srst,
   input  wire logic [31:0]         s_axi_awaddr,
   input  wire logic                s_axi_awvalid,
   output logic                     s_axi_awready,
   input  wire logic [31:0]         s_axi_wdata,
   input  wire logic [3:0]          s_axi_wstrb,
   input  wire logic                s_axi_wvalid,
   output logic                     s_axi_wready,
   output logic [1:0]               s_axi_bresp,
   output logic                     s_axi_bvalid,
   input  wire logic                s_axi_bready,
   input  wire logic [31:0]         s_axi_araddr,
   input  wire logic                s_axi_arvalid,
   output logic                     s_axi_arready,
   output logic [31:0]              s_axi_rdata,
   output logic [1:0]               s_axi_rresp,
   output logic                     s_axi_rvalid,
   input  wire logic                s_axi_rready,
   input  wire logic [SAMPLE_W-1:0] spk_dma_sample,
   input  wire logic                spk_dma_valid,
   output logic                     spk_dma_take,
   input  wire logic                dac_sample_tick,
   output logic [SAMPLE_W-1:0]      dac_sample,
   output logic                     dac_reference_enable,
   output logic                     spk_page_stop_select,
   output logic                     irq
);

   // ************************************************
   // Register state
   // ************************************************
   logic [15:0]         settle_ff;
   logic [SAMPLE_W-1:0] sample_ff;
   logic                full_ff;
   logic                ref_en_ff;
   logic                page_stop_ff;
   logic                spk_en_ff;
   logic [`IRQ_W-1:0]   stat_ff;
   logic [`IRQ_W-1:0]   mask_ff;
   logic [SAMPLE_W-1:0] dac_ff;
   logic                take_ff;
   logic                irq_ff;
   spk_state_t          state_ff;
   spk_state_t          nxt_state;

   // ************************************************
   // AXI4-Lite write side
   // ************************************************
   logic        aw_held_ff;
   logic        w_held_ff;
   logic [31:0] awaddr_ff;
   logic [31:0] wdata_ff;
   logic [3:0]  wstrb_ff;
   logic        bvalid_ff;
   logic [1:0]  bresp_ff;

   function automatic logic hit_reg(input logic [31:0] a,
                                    input logic [31:0] idx);
      hit_reg = (a == `BYTE_ADDR(idx));
   endfunction

   wire aw_take  = s_axi_awvalid && !aw_held_ff && !bvalid_ff;
   wire w_take   = s_axi_wvalid && !w_held_ff && !bvalid_ff;
   wire aw_have  = aw_held_ff || aw_take;
   wire w_have   = w_held_ff || w_take;
   wire wr_fire  = aw_have && w_have && !bvalid_ff;
   wire [31:0] wa = aw_held_ff ? awaddr_ff : s_axi_awaddr;
   wire [31:0] wd = w_held_ff ? wdata_ff : s_axi_wdata;
   wire [3:0]  ws = w_held_ff ? wstrb_ff : s_axi_wstrb;
   wire lo_en    = ws[0];
   wire hi_en    = ws[1];

   wire wr_settle = wr_fire && hit_reg(wa, `IDX_SETTLE);
   wire wr_sample = wr_fire && hit_reg(wa, `IDX_SAMPLE);
   wire wr_ctl    = wr_fire && hit_reg(wa, `IDX_CONTROL);
   wire wr_seq    = wr_fire && hit_reg(wa, `IDX_SEQ);
   wire wr_stat   = wr_fire && hit_reg(wa, `IDX_IRQ_STAT);
   wire wr_mask   = wr_fire && hit_reg(wa, `IDX_IRQ_MASK);
   wire wr_known  = wr_settle || wr_sample || wr_ctl || wr_seq
                    || wr_stat || wr_mask;

   assign s_axi_awready = !aw_held_ff && !bvalid_ff;
   assign s_axi_wready  = !w_held_ff && !bvalid_ff;
   assign s_axi_bvalid  = bvalid_ff;
   assign s_axi_bresp   = bresp_ff;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         aw_held_ff <= 1'b0;
         w_held_ff  <= 1'b0;
         awaddr_ff  <= 32'h00000000;
         wdata_ff   <= 32'h00000000;
         wstrb_ff   <= 4'h0;
         bvalid_ff  <= 1'b0;
         bresp_ff   <= `RESP_OKAY;
      end else begin
         if (aw_take) awaddr_ff <= s_axi_awaddr;
         if (w_take) begin
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
         end
         aw_held_ff <= aw_have && !wr_fire;
         w_held_ff  <= w_have && !wr_fire;
         if (wr_fire) begin
            bvalid_ff <= 1'b1;
            bresp_ff  <= wr_known ? `RESP_OKAY : `RESP_SLVERR;
         end else if (s_axi_bready) begin
            bvalid_ff <= 1'b0;
         end
      end
   end

   // ************************************************
   // Speaker state machine
   // ************************************************
   logic settle_done;
   wire  ref_rise  = wr_ctl && hi_en && wd[`CTL_REF_EN_BIT] && !ref_en_ff;
   wire  running   = (state_ff == ST_RUN);
   wire  present   = running && dac_sample_tick && full_ff;
   wire  underrun  = running && dac_sample_tick && !full_ff;
   wire  refill    = spk_en_ff && !full_ff && spk_dma_valid && !take_ff;

   settle_timer u_settle (
      .sys_clk (sys_clk),
      .srst    (srst),
      .start   (ref_rise),
      .clear   (!ref_en_ff && !ref_rise),
      .limit   (settle_ff),
      .done    (settle_done)
   );

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         ST_OFF:    if (spk_en_ff && ref_en_ff) nxt_state = ST_SETTLE;
         ST_SETTLE: if (settle_done) nxt_state = ST_RUN; // see R13
         ST_RUN:    nxt_state = ST_RUN;
         default:   nxt_state = ST_OFF;
      endcase
      if (!spk_en_ff || !ref_en_ff) nxt_state = ST_OFF;
   end

   // ************************************************
   // Registers and datapath
   // ************************************************
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         settle_ff    <= `SETTLE_RESET;
         ref_en_ff    <= 1'b0;
         page_stop_ff <= 1'b0;
         spk_en_ff    <= 1'b0;
         mask_ff      <= '0;
         state_ff     <= ST_OFF;
      end else begin
         if (wr_settle && lo_en) settle_ff[7:0] <= wd[7:0];  // see R1
         if (wr_settle && hi_en) settle_ff[15:8] <= wd[15:8];  // see R1
         if (wr_ctl && hi_en) ref_en_ff <= wd[`CTL_REF_EN_BIT];  // see R7
         if (wr_ctl && lo_en) page_stop_ff <= wd[`CTL_PAGE_STOP_BIT]; // see R11
         if (wr_seq && lo_en) spk_en_ff <= wd[`SEQ_SPK_EN_BIT];
         if (wr_mask && lo_en) mask_ff <= wd[`IRQ_W-1:0];
         state_ff <= nxt_state;
      end
   end

   // Sample register; disabling the block wins over every other source
   always_ff @(posedge sys_clk) begin
      if (srst || !spk_en_ff) begin
         sample_ff <= `SAMPLE_MIDSCALE;  // see R6
         full_ff   <= 1'b0;
      end else if (wr_sample && (lo_en || hi_en)) begin
         sample_ff <= wd[SAMPLE_W-1:0];  // see R5
         full_ff   <= 1'b1;
      end else if (refill) begin
         sample_ff <= spk_dma_sample;  // see R12
         full_ff   <= 1'b1;
      end else if (present) begin
         full_ff   <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         dac_ff  <= `SAMPLE_MIDSCALE;
         take_ff <= 1'b0;
      end else begin
         if (!spk_en_ff) dac_ff <= `SAMPLE_MIDSCALE;
         else if (present) dac_ff <= sample_ff;  // see R3
         take_ff <= refill && !wr_sample;
      end
   end

   // Set wins over a write-one clear landing in the same cycle
   wire [`IRQ_W-1:0] irq_set = {underrun, settle_done && state_ff == ST_SETTLE};
   wire [`IRQ_W-1:0] irq_clr = (wr_stat && lo_en) ? wd[`IRQ_W-1:0] : '0;
   wire [`IRQ_W-1:0] nxt_stat = (stat_ff & ~irq_clr) | irq_set;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         stat_ff <= '0;
         irq_ff  <= 1'b0;
      end else begin
         stat_ff <= nxt_stat;
         irq_ff  <= |(nxt_stat & mask_ff);
      end
   end

   assign dac_sample           = dac_ff;
   assign dac_reference_enable = ref_en_ff;
   assign spk_page_stop_select = page_stop_ff;
   assign spk_dma_take         = take_ff;
   assign irq                  = irq_ff;

   // ************************************************
   // AXI4-Lite read side
   // ************************************************
   logic        rvalid_ff;
   logic [31:0] rdata_ff;
   logic [1:0]  rresp_ff;

   wire rd_fire = s_axi_arvalid && !rvalid_ff;
   wire [31:0] ra = s_axi_araddr;
   wire [31:0] ctl_word = {16'h0000, ref_en_ff, 11'h000,
                           running, 1'b0, page_stop_ff, 1'b0}; // see R4, R9
   wire [31:0] sample_word = {{(32-SAMPLE_W){1'b0}}, sample_ff}; // see R4
   wire ra_known = hit_reg(ra, `IDX_SETTLE) || hit_reg(ra, `IDX_SAMPLE)
                   || hit_reg(ra, `IDX_CONTROL) || hit_reg(ra, `IDX_SEQ)
                   || hit_reg(ra, `IDX_IRQ_STAT) || hit_reg(ra, `IDX_IRQ_MASK);
   wire [31:0] rd_mux =
      hit_reg(ra, `IDX_SETTLE)   ? {16'h0000, settle_ff} :
      hit_reg(ra, `IDX_SAMPLE)   ? sample_word :
      hit_reg(ra, `IDX_CONTROL)  ? ctl_word :
      hit_reg(ra, `IDX_SEQ)      ? {31'h00000000, spk_en_ff} :
      hit_reg(ra, `IDX_IRQ_STAT) ? {30'h00000000, stat_ff} :
      hit_reg(ra, `IDX_IRQ_MASK) ? {30'h00000000, mask_ff} :
                                   32'h00000000;

   assign s_axi_arready = !rvalid_ff;
   assign s_axi_rvalid  = rvalid_ff;
   assign s_axi_rdata   = rdata_ff;
   assign s_axi_rresp   = rresp_ff;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         rvalid_ff <= 1'b0;
         rdata_ff  <= 32'h00000000;
         rresp_ff  <= `RESP_OKAY;
      end else if (rd_fire) begin
         rvalid_ff <= 1'b1;
         rdata_ff  <= rd_mux;
         rresp_ff  <= ra_known ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rready) begin
         rvalid_ff <= 1'b0;
      end
   end

endmodule

`default_nettype wire

// file: tb/dac_model.sv
// Behavioural model of the speaker converter that paces the samples
`timescale 1ns/1ps
`default_nettype none

module dac_model #(
   parameter int PERIOD = 7
) (
   input  wire logic sys_clk,
   input  wire logic srst,
   input  wire logic dac_reference_enable,
   output logic      dac_sample_tick
);
   logic [7:0] cnt_ff;

   // Converter only asks for samples while its reference is powered
   always_ff @(posedge sys_clk) begin
      if (srst || !dac_reference_enable) begin
         cnt_ff          <= 8'h00;
         dac_sample_tick <= 1'b0;
      end else begin
         cnt_ff          <= (cnt_ff == 8'(PERIOD - 1)) ? 8'h00 : cnt_ff + 8'h01;
         dac_sample_tick <= (cnt_ff == 8'(PERIOD - 1));
      end
   end
endmodule
`default_nettype wire

// file: tb/spk_dac_monitor.sv
// Concurrent checks on the speaker DAC control ports
`timescale 1ns/1ps
`default_nettype none
`include "spk_dac_cfg.svh"

module spk_dac_monitor #(
   parameter int SAMPLE_W = 10
) (
   input wire logic                sys_clk,
   input wire logic                srst,
   input wire logic [31:0]         s_axi_awaddr,
   input wire logic                s_axi_awvalid,
   input wire logic                s_axi_awready,
   input wire logic [31:0]         s_axi_wdata,
   input wire logic [3:0]          s_axi_wstrb,
   input wire logic                s_axi_wvalid,
   input wire logic                s_axi_wready,
   input wire logic                s_axi_bvalid,
   input wire logic                s_axi_arvalid,
   input wire logic                s_axi_arready,
   input wire logic                s_axi_rvalid,
   input wire logic                spk_dma_take,
   input wire logic                dac_sample_tick,
   input wire logic [SAMPLE_W-1:0] dac_sample,
   input wire logic                dac_reference_enable,
   input wire logic                spk_page_stop_select,
   input wire logic                irq
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);

   wire wr_both = s_axi_awvalid & s_axi_awready & s_axi_wvalid & s_axi_wready;
   // Both low lanes, so each control bit is known to be written
   wire ctl_wr  = wr_both && (s_axi_wstrb[1:0] == 2'b11)
                  && (s_axi_awaddr == `BYTE_ADDR(`IDX_CONTROL));

   chk_reset_midscale: assert property (
      $fell(srst) |-> dac_sample == 10'h200 && !dac_reference_enable)
      else $error("output not at midscale after reset");
   chk_ref_enable_wr: assert property (
      ctl_wr |=> dac_reference_enable == $past(s_axi_wdata[15]))
      else $error("reference enable does not follow control bit 15");
   chk_page_select_wr: assert property (
      ctl_wr |=> spk_page_stop_select == $past(s_axi_wdata[1]))
      else $error("page stop select does not follow control bit 1");
   chk_settle_hold: assert property (
      $rose(dac_reference_enable) |-> $stable(dac_sample)[*8])
      else $error("sample presented while reference settles");
   chk_dac_source: assert property (
      $changed(dac_sample) |-> $past(dac_sample_tick) || dac_sample == 10'h200)
      else $error("converter value changed without a tick");
   chk_take_pulse: assert property (
      spk_dma_take |=> !spk_dma_take)
      else $error("dma take longer than one cycle");
   chk_write_answer: assert property (
      wr_both |=> s_axi_bvalid)
      else $error("write response late");
   chk_read_answer: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read response late");

   cover property (spk_dma_take);
   cover property (irq);
   cover property ($rose(dac_reference_enable));
endmodule

bind speaker_dac_output_control spk_dac_monitor #(.SAMPLE_W(SAMPLE_W))
   u_spk_dac_monitor (.sys_clk(sys_clk), .srst(srst),
   .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
   .s_axi_wstrb(s_axi_wstrb),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
   .spk_dma_take(spk_dma_take), .dac_sample_tick(dac_sample_tick),
   .dac_sample(dac_sample), .dac_reference_enable(dac_reference_enable),
   .spk_page_stop_select(spk_page_stop_select), .irq(irq));
`default_nettype wire

// file: tb/tb.sv
// Register-level testbench of the speaker DAC control block
`timescale 1ns/1ps
`default_nettype none
`include "spk_dac_cfg.svh"

module tb;
   import spk_dac_pkg::*;
   logic        sys_clk = 1'b0;
   logic        srst = 1'b1;
   logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0;
   logic [31:0] s_axi_araddr = 32'h0, s_axi_rdata;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic        s_axi_rvalid, spk_dma_valid = 1'b0, spk_dma_take;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic [9:0]  spk_dma_sample = 10'h000, dac_sample;
   logic        dac_sample_tick, dac_reference_enable, spk_page_stop_select;
   logic        irq;
   int          bad_count = 0, num_checks = 0;

`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin bad_count++; \
   $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end

   always #2.5 sys_clk = ~sys_clk;

   speaker_dac_output_control u_speaker_dac_output_control (
      .sys_clk(sys_clk), .srst(srst), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .spk_dma_sample(spk_dma_sample), .spk_dma_valid(spk_dma_valid),
      .spk_dma_take(spk_dma_take), .dac_sample_tick(dac_sample_tick),
      .dac_sample(dac_sample), .dac_reference_enable(dac_reference_enable),
      .spk_page_stop_select(spk_page_stop_select), .irq(irq));

   // Short period, so an early presentation shows inside the settle check
   dac_model #(.PERIOD(5)) u_dac_model (.sys_clk(sys_clk), .srst(srst),
      .dac_reference_enable(dac_reference_enable),
      .dac_sample_tick(dac_sample_tick));

   // ****************************************
   // Bus tasks
   // ****************************************
   // Ready is looked at mid-cycle so the edge decision never races
   task automatic wr(input logic [31:0] ix, input logic [31:0] d,
                     input logic [1:0] er);
      int   n = 0;
      logic a, w, b = 1'b0;
      @(posedge sys_clk);
      s_axi_awaddr  <= `BYTE_ADDR(ix);
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      while (!b && n < 100) begin
         @(negedge sys_clk);
         a = s_axi_awvalid & s_axi_awready;
         w = s_axi_wvalid & s_axi_wready;
         b = s_axi_bvalid;
         if (b) `CHK(s_axi_bresp, er)
         @(posedge sys_clk);
         if (a) s_axi_awvalid <= 1'b0;
         if (w) s_axi_wvalid <= 1'b0;
         n++;
      end
      s_axi_bready <= 1'b0;
      `CHK(b, 1'b1)
   endtask

   task automatic rd(input logic [31:0] ix, input logic [31:0] e,
                     input logic [1:0] er);
      int   n = 0;
      logic a, r = 1'b0;
      @(posedge sys_clk);
      s_axi_araddr  <= `BYTE_ADDR(ix);
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      while (!r && n < 100) begin
         @(negedge sys_clk);
         a = s_axi_arvalid & s_axi_arready;
         r = s_axi_rvalid;
         if (r) `CHK({s_axi_rresp, s_axi_rdata}, {er, e})
         @(posedge sys_clk);
         if (a) s_axi_arvalid <= 1'b0;
         n++;
      end
      s_axi_rready <= 1'b0;
      `CHK(r, 1'b1)
   endtask

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // ****************************************
   // Tests
   // ****************************************
   initial begin
      int n;
      repeat (20) @(posedge sys_clk);
      srst <= 1'b0;
      rd(`IDX_SETTLE, 32'h007d, `RESP_OKAY);
      rd(`IDX_SAMPLE, 32'h0200, `RESP_OKAY);
      rd(`IDX_CONTROL, 32'h0000, `RESP_OKAY);
      wr(`IDX_SETTLE, 32'hffff, `RESP_OKAY);
      rd(`IDX_SETTLE, 32'hffff, `RESP_OKAY);
      wr(`IDX_SETTLE, `SETTLE_CYCLES, `RESP_OKAY);
      wr(`IDX_SAMPLE, 32'h0155, `RESP_OKAY);
      rd(`IDX_SAMPLE, 32'h0200, `RESP_OKAY);
      wr(`IDX_SEQ, 32'h0001, `RESP_OKAY);
      rd(`IDX_SEQ, 32'h0001, `RESP_OKAY);
      wr(`IDX_SAMPLE, 32'hffff, `RESP_OKAY);
      rd(`IDX_SAMPLE, 32'h03ff, `RESP_OKAY);
      wr(`IDX_IRQ_MASK, 32'h0001, `RESP_OKAY);
      rd(`IDX_IRQ_MASK, 32'h0001, `RESP_OKAY);
      wr(`IDX_CONTROL, 32'hffff, `RESP_OKAY);
      rd(`IDX_CONTROL, 32'h8002, `RESP_OKAY);
      @(negedge sys_clk);
      `CHK({dac_reference_enable, spk_page_stop_select}, 2'b11)
      `CHK({irq, dac_sample}, {1'b0, 10'h200})
      repeat (`SETTLE_CYCLES + 40) @(posedge sys_clk);
      rd(`IDX_CONTROL, 32'h800a, `RESP_OKAY);
      @(negedge sys_clk);
      `CHK({irq, dac_sample}, {1'b1, 10'h3ff})
      wr(`IDX_IRQ_STAT, 32'h0001, `RESP_OKAY);
      @(negedge sys_clk);
      `CHK(irq, 1'b0)
      rd(`IDX_IRQ_STAT, 32'h0002, `RESP_OKAY);
      @(posedge sys_clk);
      spk_dma_sample <= 10'h123;
      spk_dma_valid  <= 1'b1;
      for (n = 0; n < 60 && spk_dma_take !== 1'b1; n++) @(negedge sys_clk);
      `CHK(spk_dma_take, 1'b1)
      @(posedge sys_clk);
      spk_dma_valid <= 1'b0;
      for (n = 0; n < 60 && dac_sample !== 10'h123; n++) @(negedge sys_clk);
      `CHK(dac_sample, 10'h123)
      wr(`IDX_SEQ, 32'h0000, `RESP_OKAY);
      repeat (2) @(negedge sys_clk);
      `CHK(dac_sample, 10'h200)
      rd(`IDX_SAMPLE, 32'h0200, `RESP_OKAY);
      rd(`IDX_CONTROL, 32'h8002, `RESP_OKAY);
      wr(32'h0, 32'h1, `RESP_SLVERR);
      rd(32'h0, 32'h0, `RESP_SLVERR);
      wr(`IDX_CONTROL, 32'h0000, `RESP_OKAY);
      rd(`IDX_CONTROL, 32'h0000, `RESP_OKAY);
      `CHK(dac_reference_enable, 1'b0)
      s_axi_wstrb <= 4'h1;
      wr(`IDX_SETTLE, 32'h0000, `RESP_OKAY);
      s_axi_wstrb <= 4'hf;
      rd(`IDX_SETTLE, 32'h0300, `RESP_OKAY);
      tally_and_finish;
   end

   // Whole run needs under two thousand cycles
   initial begin
      repeat (6000) @(posedge sys_clk);
      bad_count++;
      tally_and_finish;
   end
endmodule
`default_nettype wire
